// ### verilog/scpm_map.svh
// register offsets, field positions, reset values and counts of the clock/power controller
// assumes an apb slave with a 12-bit byte address and 32-bit data
`ifndef SCPM_MAP_SVH
`define SCPM_MAP_SVH
// byte addresses
`define SCPM_ADDR_SYS_MODE 12'h000
`define SCPM_ADDR_CTRL 12'h004
`define SCPM_ADDR_SUB_SEL 12'h008
`define SCPM_ADDR_STATUS 12'h00c
// system mode register fields
`define SCPM_HIGH_LOW_CLOCK_SEL_BIT 0
`define SCPM_IDLE_ON_HALT_ENABLE_BIT 1
`define SCPM_HTO_BIT 2
`define SCPM_LTO_BIT 3
`define SCPM_CKS_LSB 5
`define SCPM_SYS_MODE_RST 8'h03
// control register fields
`define SCPM_BADCODE_BIT 3
`define SCPM_FSYSKEEP_BIT 7
// sub clock select fields
`define SCPM_CRYSTAL_LOW_POWER_SEL_BIT 7
`define SCPM_SUB_SEL_RST 8'h2a
`define SCPM_CODE_LOW_SPEED_RC 7'h2a
`define SCPM_CODE_LXT 7'h55
// ready counts in oscillator edges
`define SCPM_LXT_READY 1024
`define SCPM_LOW_SPEED_RC_READY 2
`define SCPM_HS_READY 16
`endif

// ### verilog/scpm_pkg.sv
// types of the clock/power controller
// assumes nothing beyond a systemverilog compiler
package scpm_pkg;
  // operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_NORMAL = 6'h01,
    MODE_SLOW = 6'h02,
    MODE_DEEP_SLEEP = 6'h04,
    MODE_LIGHT_SLEEP = 6'h08,
    MODE_IDLE_OFF = 6'h10,
    MODE_IDLE_ON = 6'h20
  } scpm_mode_type;

  // clock and power gates driven to the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic sub_clk_en;
    logic tbc_clk_en;
    logic hs_osc_en;
    logic lxt_en;
    logic low_speed_rc_en;
    logic lxt_low_power;
    logic lvd_bandgap_keep;
    logic periph_off;
  } scpm_gates_type;
endpackage : scpm_pkg

// ### verilog/scpm_top.sv
// clock source selection and operating mode control, with apb registers
// assumes oscillator waveforms arrive as asynchronous pins; halt, wake, wdt and lvd
// enables come from logic on ref_clk
`include "scpm_map.svh"

// Summary of operation
// - bit 7 of sub_clock_select: 0 quick-start crystal drive, 1 low-power drive.
// - code 0101010 picks RC, 1010101 picks crystal, others request reset.
// - reset clears the crystal low-power bit, so crystal starts quick.
// - crystal runs in either drive; low power only starts slower.
// - low-speed clock comes from crystal or RC per the seven-bit code.
// - normal mode system clock is high-speed divided by 1 to 64.
// - system clock moving to low-speed stops the high-speed oscillator.
// - six modes; cpu clocked only in normal and slow.
// - slow mode runs from low-speed clock with high-speed off.
// - halt, idle off, voltage detect and watchdog off enters deep sleep; low clock stops.
// - light sleep stops cpu; low clock runs if lvd or watchdog on.
// - halt with idle on, keep off: idle with system oscillator stopped.
// - halt with idle on, keep on: idle with system oscillator running.
// - voltage detect enabled in sleep/idle keeps lvd, bandgap, low clock on.
// - light sleep disables peripherals except enabled watchdog and lvd.
// - divider code 000/001 low-speed, 010..111 high-speed /64 down to /2.
// - low ready flag clears in deep sleep, sets after 1024 or 2 edges.
// - high ready flag clears in sleep or idle-off, sets after 16 edges.
// - undefined source code sets a sticky flag cleared only by software.
module scpm_top #(
  parameter int DIV_STAGES = 6,
  parameter int LXT_READY = `SCPM_LXT_READY,
  parameter int LOW_SPEED_RC_READY = `SCPM_LOW_SPEED_RC_READY,
  parameter int HS_READY = `SCPM_HS_READY
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator waveforms
  input wire logic hs_osc_in,
  input wire logic low_speed_rc_osc_in,
  input wire logic lxt_osc_in,
  // cpu and neighbours
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enable,
  input wire logic voltage_detect_enable,
  // clock outputs and gates
  output logic system_clock,
  output scpm_pkg::scpm_gates_type gates,
  output scpm_pkg::scpm_mode_type mode,
  output logic mcu_reset_req
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (DIV_STAGES != 6) begin : g_bad_div
    $error("divider must have six stages");
  end
  if (LXT_READY < 2 || LXT_READY > 2047 || LOW_SPEED_RC_READY < 1 || LOW_SPEED_RC_READY > 2047) begin : g_bad_l
    $error("low ready count out of range");
  end
  if (HS_READY < 1 || HS_READY > 31) begin : g_bad_h
    $error("high ready count out of range");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // source 0 low-speed, 1 high-speed, 2..7 high-speed /64 .. /2
  function automatic logic src_level(input logic [2:0] src, input logic sub,
                                     input logic hs, input logic [5:0] div);
    if (src == 3'h0) return sub;
    if (src == 3'h1) return hs;
    return div[3'h7 - src];
  endfunction : src_level

  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    return a == reg_addr;
  endfunction : hit

  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  logic [2:0] pin_meta_q, pin_sync_q, pin_last_q, pin_rise;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      pin_last_q <= 3'h0;
    end else begin
      pin_meta_q <= {lxt_osc_in, low_speed_rc_osc_in, hs_osc_in};
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end
  assign pin_rise = pin_sync_q & ~pin_last_q;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0] cks_q, cks_d;
  logic idle_on_halt_enable_q, idle_on_halt_enable_d, high_low_clock_sel_q, high_low_clock_sel_d;
  logic system_clock_keep_q, system_clock_keep_d, bad_code_q, bad_code_d;
  logic [7:0] sub_sel_q, sub_sel_d;
  logic rst_req_q, rst_req_d;
  logic [31:0] prdata_q, prdata_d;
  logic lto_q, hto_q;
  logic [2:0] cur_src_q;
  scpm_pkg::scpm_mode_type mode_q;
  logic wr_en, rd_setup, code_bad;
  logic [6:0] new_code;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign new_code = pwdata[6:0];
  assign code_bad = new_code != `SCPM_CODE_LOW_SPEED_RC && new_code != `SCPM_CODE_LXT;

  always_comb begin
    cks_d = cks_q;
    idle_on_halt_enable_d = idle_on_halt_enable_q;
    high_low_clock_sel_d = high_low_clock_sel_q;
    system_clock_keep_d = system_clock_keep_q;
    bad_code_d = bad_code_q;
    sub_sel_d = sub_sel_q;
    rst_req_d = 1'b0;
    prdata_d = prdata_q;
    if (wr_en && hit(paddr, `SCPM_ADDR_SYS_MODE)) begin
      cks_d = pwdata[`SCPM_CKS_LSB +: 3];
      idle_on_halt_enable_d = pwdata[`SCPM_IDLE_ON_HALT_ENABLE_BIT];
      high_low_clock_sel_d = pwdata[`SCPM_HIGH_LOW_CLOCK_SEL_BIT];
    end
    if (wr_en && hit(paddr, `SCPM_ADDR_CTRL)) begin
      system_clock_keep_d = pwdata[`SCPM_FSYSKEEP_BIT];
      bad_code_d = pwdata[`SCPM_BADCODE_BIT] & bad_code_q;
    end
    if (wr_en && hit(paddr, `SCPM_ADDR_SUB_SEL)) begin
      sub_sel_d[`SCPM_CRYSTAL_LOW_POWER_SEL_BIT] = pwdata[`SCPM_CRYSTAL_LOW_POWER_SEL_BIT];
      if (code_bad) begin
        // undefined code: reset request, code back to its default
        sub_sel_d[6:0] = 7'(`SCPM_SUB_SEL_RST);
        sub_sel_d[`SCPM_CRYSTAL_LOW_POWER_SEL_BIT] = 1'b0;
        rst_req_d = 1'b1;
        bad_code_d = 1'b1; // set wins over a clear
      end else begin
        sub_sel_d[6:0] = new_code;
      end
    end
    if (rd_setup) begin
      prdata_d = 32'h0;
      unique case (1'b1)
        hit(paddr, `SCPM_ADDR_SYS_MODE): begin
          prdata_d[`SCPM_CKS_LSB +: 3] = cks_q;
          prdata_d[`SCPM_LTO_BIT] = lto_q;
          prdata_d[`SCPM_HTO_BIT] = hto_q;
          prdata_d[`SCPM_IDLE_ON_HALT_ENABLE_BIT] = idle_on_halt_enable_q;
          prdata_d[`SCPM_HIGH_LOW_CLOCK_SEL_BIT] = high_low_clock_sel_q;
        end
        hit(paddr, `SCPM_ADDR_CTRL): begin
          prdata_d[`SCPM_FSYSKEEP_BIT] = system_clock_keep_q;
          prdata_d[`SCPM_BADCODE_BIT] = bad_code_q;
        end
        hit(paddr, `SCPM_ADDR_SUB_SEL): prdata_d[7:0] = sub_sel_q;
        hit(paddr, `SCPM_ADDR_STATUS): prdata_d[10:0] = {cur_src_q, 2'h0, mode_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cks_q <= 3'(`SCPM_SYS_MODE_RST >> `SCPM_CKS_LSB);
      idle_on_halt_enable_q <= 1'b1;
      high_low_clock_sel_q <= 1'b1;
      system_clock_keep_q <= 1'b0;
      bad_code_q <= 1'b0;
      sub_sel_q <= `SCPM_SUB_SEL_RST; // crystal low-power bit cleared
      rst_req_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      cks_q <= cks_d;
      idle_on_halt_enable_q <= idle_on_halt_enable_d;
      high_low_clock_sel_q <= high_low_clock_sel_d;
      system_clock_keep_q <= system_clock_keep_d;
      bad_code_q <= bad_code_d;
      sub_sel_q <= sub_sel_d;
      rst_req_q <= rst_req_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit(paddr, `SCPM_ADDR_SYS_MODE) ||
                   hit(paddr, `SCPM_ADDR_CTRL) || hit(paddr, `SCPM_ADDR_SUB_SEL) ||
                   hit(paddr, `SCPM_ADDR_STATUS));
  assign prdata = prdata_q;
  assign mcu_reset_req = rst_req_q;

  // ****************************************************************
  // operating mode and clock mux
  // ****************************************************************
  logic use_lxt, sub_level, hs_level, run, idle_on, sub_on, on_low;
  logic [5:0] div_q, div_d;
  logic [2:0] sel_src, cur_src_d;
  logic sys_clk_q, sys_clk_d;
  scpm_pkg::scpm_mode_type mode_d;

  assign use_lxt = sub_sel_q[6:0] == `SCPM_CODE_LXT;
  assign sub_level = use_lxt ? pin_sync_q[2] : pin_sync_q[1];
  assign hs_level = pin_sync_q[0];
  // divider code 000/001 means low-speed
  assign sel_src = high_low_clock_sel_q ? 3'h1 : ((cks_q < 3'h2) ? 3'h0 : cks_q);
  assign run = mode_q == scpm_pkg::MODE_NORMAL || mode_q == scpm_pkg::MODE_SLOW;
  assign idle_on = mode_q == scpm_pkg::MODE_IDLE_ON;
  assign on_low = cur_src_q == 3'h0 && sel_src == 3'h0;

  always_comb begin
    mode_d = mode_q;
    cur_src_d = cur_src_q;
    div_d = div_q;
    if (pin_rise[0]) begin
      div_d = div_q + 6'h1;
    end
    // switch only while both clocks sit low
    if ((run || idle_on) && sel_src != cur_src_q &&
        !src_level(cur_src_q, sub_level, hs_level, div_q) &&
        !src_level(sel_src, sub_level, hs_level, div_q)) begin
      cur_src_d = sel_src;
    end
    unique case (mode_q)
      scpm_pkg::MODE_NORMAL, scpm_pkg::MODE_SLOW: begin
        mode_d = on_low ? scpm_pkg::MODE_SLOW : scpm_pkg::MODE_NORMAL;
        if (halt_req) begin
          if (idle_on_halt_enable_q) begin
            mode_d = system_clock_keep_q ? scpm_pkg::MODE_IDLE_ON : scpm_pkg::MODE_IDLE_OFF;
          end else if (!voltage_detect_enable && !wdt_enable) begin
            mode_d = scpm_pkg::MODE_DEEP_SLEEP;
          end else begin
            mode_d = scpm_pkg::MODE_LIGHT_SLEEP;
          end
        end
      end
      scpm_pkg::MODE_DEEP_SLEEP, scpm_pkg::MODE_LIGHT_SLEEP,
      scpm_pkg::MODE_IDLE_OFF, scpm_pkg::MODE_IDLE_ON: begin
        if (wake_req) begin
          mode_d = on_low ? scpm_pkg::MODE_SLOW : scpm_pkg::MODE_NORMAL;
        end
      end
      default: mode_d = scpm_pkg::MODE_NORMAL;
    endcase
    sys_clk_d = (run || idle_on) && src_level(cur_src_q, sub_level, hs_level, div_q);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= scpm_pkg::MODE_NORMAL;
      cur_src_q <= 3'h1;
      div_q <= 6'h0;
      sys_clk_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cur_src_q <= cur_src_d;
      div_q <= div_d;
      sys_clk_q <= sys_clk_d;
    end
  end

  assign system_clock = sys_clk_q;
  assign mode = mode_q;

  // ****************************************************************
  // clock and power gates
  // ****************************************************************
  // low clock: off only in deep sleep, or light sleep with lvd and wdt off
  assign sub_on = !(mode_q == scpm_pkg::MODE_DEEP_SLEEP) &&
                  !(mode_q == scpm_pkg::MODE_LIGHT_SLEEP && !wdt_enable &&
                    !voltage_detect_enable) || voltage_detect_enable;
  assign gates.cpu_clk_en = run;
  assign gates.sys_clk_en = run || idle_on;
  assign gates.sub_clk_en = sub_on;
  assign gates.tbc_clk_en = run || idle_on || mode_q == scpm_pkg::MODE_IDLE_OFF;
  // high-speed stops once both the mux and the selection sit on low-speed
  assign gates.hs_osc_en = mode_q == scpm_pkg::MODE_NORMAL || (idle_on && cur_src_q != 3'h0);
  assign gates.lxt_en = sub_on && use_lxt;
  assign gates.low_speed_rc_en = sub_on && !use_lxt;
  assign gates.lxt_low_power = sub_sel_q[`SCPM_CRYSTAL_LOW_POWER_SEL_BIT];
  assign gates.lvd_bandgap_keep = voltage_detect_enable && !run;
  assign gates.periph_off = mode_q == scpm_pkg::MODE_LIGHT_SLEEP;

  // ****************************************************************
  // ready flags
  // ****************************************************************
  logic lto_d, hto_d;
  logic [10:0] lcnt_q, lcnt_d;
  logic [4:0] hcnt_q, hcnt_d;
  logic [10:0] l_target;

  assign l_target = use_lxt ? 11'(LXT_READY) : 11'(LOW_SPEED_RC_READY);

  always_comb begin
    lto_d = lto_q;
    lcnt_d = lcnt_q;
    hto_d = hto_q;
    hcnt_d = hcnt_q;
    if (!sub_on) begin
      lto_d = 1'b0;
      lcnt_d = 11'h0;
    end else if (!lto_q && (use_lxt ? pin_rise[2] : pin_rise[1])) begin
      lcnt_d = lcnt_q + 11'h1;
      lto_d = (lcnt_q + 11'h1) >= l_target;
    end
    if (!gates.hs_osc_en) begin
      hto_d = 1'b0;
      hcnt_d = 5'h0;
    end else if (!hto_q && pin_rise[0]) begin
      hcnt_d = hcnt_q + 5'h1;
      hto_d = (hcnt_q + 5'h1) >= 5'(HS_READY);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lto_q <= 1'b0;
      lcnt_q <= 11'h0;
      hto_q <= 1'b0;
      hcnt_q <= 5'h0;
    end else begin
      lto_q <= lto_d;
      lcnt_q <= lcnt_d;
      hto_q <= hto_d;
      hcnt_q <= hcnt_d;
    end
  end

endmodule : scpm_top

// ### tb/scpm_checker.sv
// concurrent checks on the ports of the clock and power mode controller
// assumes it is bound into scpm_top and that everything runs on ref_clk
`include "scpm_map.svh"
module scpm_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // mode control
  input wire logic voltage_detect_enable,
  input wire scpm_pkg::scpm_gates_type gates,
  input wire scpm_pkg::scpm_mode_type mode,
  input wire logic mcu_reset_req
);
  logic wr_sub;
  logic asleep;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  assign wr_sub = psel && penable && pwrite && paddr == `SCPM_ADDR_SUB_SEL;
  assign asleep = !(mode inside {scpm_pkg::MODE_NORMAL, scpm_pkg::MODE_SLOW});
  // ****************************************
  // mode gating
  // ****************************************
  a_cpu_run_only: assert property (gates.cpu_clk_en == !asleep)
    else $error("cpu clock enable disagrees with mode");
  a_slow_hs_off: assert property (mode == scpm_pkg::MODE_SLOW |-> !gates.hs_osc_en)
    else $error("high-speed oscillator on in slow mode");
  a_deep_clocks_off: assert property (mode == scpm_pkg::MODE_DEEP_SLEEP && !voltage_detect_enable |->
    !gates.sub_clk_en && !gates.tbc_clk_en) else $error("clocks running in deep sleep");
  a_light_periph_off: assert property (mode == scpm_pkg::MODE_LIGHT_SLEEP |->
    gates.periph_off && !gates.sys_clk_en) else $error("peripherals on in light sleep");
  a_idle_off_sys: assert property (mode == scpm_pkg::MODE_IDLE_OFF |->
    !gates.sys_clk_en && gates.sub_clk_en) else $error("idle clock-off gating wrong");
  a_idle_on_sys: assert property (mode == scpm_pkg::MODE_IDLE_ON |->
    gates.sys_clk_en && gates.sub_clk_en) else $error("idle clock-on gating wrong");
  a_lvd_keeps_sub: assert property (asleep && voltage_detect_enable |->
    gates.sub_clk_en && gates.lvd_bandgap_keep) else $error("detector kept no low clock");
  // ****************************************
  // sub clock select register and unmapped accesses
  // ****************************************
  a_drive_bit_follows: assert property (wr_sub && pwdata[6:0] == `SCPM_CODE_LXT |=>
    gates.lxt_low_power == $past(pwdata[7])) else $error("crystal drive bit not applied");
  a_bad_code_reset: assert property (wr_sub && !(pwdata[6:0] inside
    {`SCPM_CODE_LOW_SPEED_RC, `SCPM_CODE_LXT}) |-> ##[1:2] mcu_reset_req)
    else $error("no reset request after undefined code");
  a_unmapped_err: assert property (psel && penable && paddr > `SCPM_ADDR_STATUS |->
    pslverr && pready) else $error("unmapped access not refused");
  c_idle_on: cover property (mode == scpm_pkg::MODE_IDLE_ON);
  c_deep: cover property (mode == scpm_pkg::MODE_DEEP_SLEEP);
  c_bad_code: cover property (mcu_reset_req);
endmodule : scpm_checker

bind scpm_top scpm_checker i_scpm_checker (.ref_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .voltage_detect_enable, .gates, .mode, .mcu_reset_req);

// ### tb/system_clock_and_power_modes_tb_top.sv
// self-checking bench for the clock and power mode controller
// assumes scpm_top with shortened ready counts and the checker bound in
`include "scpm_map.svh"
module system_clock_and_power_modes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, rst_seen = 0;
  logic hs_osc_in = 0, low_speed_rc_osc_in = 0, lxt_osc_in = 0;
  logic halt_req = 0, wake_req = 0, wdt_enable = 0, voltage_detect_enable = 0;
  logic system_clock, mcu_reset_req;
  scpm_pkg::scpm_gates_type gates;
  scpm_pkg::scpm_mode_type mode;
  int bad_count = 0, compares = 0, cyc = 0;
  scpm_top #(.LXT_READY(8), .HS_READY(4)) i_scpm_top (.ref_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hs_osc_in, .low_speed_rc_osc_in,
    .lxt_osc_in, .halt_req, .wake_req, .wdt_enable, .voltage_detect_enable, .system_clock,
    .gates, .mode, .mcu_reset_req);
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // oscillator pins: high speed period 8 cycles, rc 20, crystal 24
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) hs_osc_in <= ~hs_osc_in;
    if (cyc % 10 == 9) low_speed_rc_osc_in <= ~low_speed_rc_osc_in;
    if (cyc % 12 == 11) lxt_osc_in <= ~lxt_osc_in;
    if (mcu_reset_req === 1'b1) rst_seen <= 1'b1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask : apb
  task automatic pulse(input logic halt);
    if (halt) halt_req <= 1;
    else wake_req <= 1;
    @(posedge ref_clk);
    halt_req <= 0;
    wake_req <= 0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    apb(0, `SCPM_ADDR_SUB_SEL, 0);
    chk("sub_clock_select", rd, 32'h2a);
    apb(0, `SCPM_ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h0);
    apb(0, `SCPM_ADDR_SYS_MODE, 0);
    chk("sys_mode", rd & 32'hf3, 32'h03);
    chk("low power drive", gates.lxt_low_power, 1'b0);
  endtask : t_reset_values
  task automatic t_sub_select();
    apb(1, `SCPM_ADDR_SUB_SEL, 32'hd5);
    apb(0, `SCPM_ADDR_SUB_SEL, 0);
    chk("sub_clock_select", rd, 32'hd5);
    chk("crystal on", gates.lxt_en, 1'b1);
    chk("low power drive", gates.lxt_low_power, 1'b1);
    apb(1, `SCPM_ADDR_SUB_SEL, 32'h2a);
    chk("rc on", gates.low_speed_rc_en, 1'b1);
    chk("quick drive", gates.lxt_low_power, 1'b0);
  endtask : t_sub_select
  task automatic t_bad_code();
    rst_seen = 0;
    apb(1, `SCPM_ADDR_SUB_SEL, 32'h13);
    repeat (2) @(posedge ref_clk);
    chk("reset request", rst_seen, 1'b1);
    apb(0, `SCPM_ADDR_SUB_SEL, 0);
    chk("code restored", rd, 32'h2a);
    apb(1, `SCPM_ADDR_CTRL, 32'h08);
    apb(0, `SCPM_ADDR_CTRL, 0);
    chk("flag kept", rd[3], 1'b1);
    apb(1, `SCPM_ADDR_CTRL, 32'h00);
    apb(0, `SCPM_ADDR_CTRL, 0);
    chk("flag cleared", rd[3], 1'b0);
    apb(1, 12'h010, 32'hff);
    chk("unmapped error", err_seen, 1'b1);
    apb(0, 12'h010, 0);
    chk("unmapped read", rd, 32'h0);
  endtask : t_bad_code
  task automatic t_halt(input logic idl, input logic keep, input logic lvd, input logic wdt,
                        input scpm_pkg::scpm_mode_type exp);
    apb(1, `SCPM_ADDR_SYS_MODE, {30'h0, idl, 1'b1});
    apb(1, `SCPM_ADDR_CTRL, {24'h0, keep, 7'h0});
    voltage_detect_enable <= lvd;
    wdt_enable <= wdt;
    @(posedge ref_clk);
    pulse(1);
    chk("halt mode", mode, exp);
    chk("cpu stopped", gates.cpu_clk_en, 1'b0);
    pulse(0);
    chk("woken mode", mode, scpm_pkg::MODE_NORMAL);
  endtask : t_halt
  task automatic t_divider();
    int n;
    int edges;
    logic prev;
    apb(1, `SCPM_ADDR_SYS_MODE, 32'h02);
    n = 0;
    while (mode !== scpm_pkg::MODE_SLOW && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("slow mode", mode, scpm_pkg::MODE_SLOW);
    chk("hs stopped", gates.hs_osc_en, 1'b0);
    apb(0, `SCPM_ADDR_SYS_MODE, 0);
    chk("high ready off", rd[2], 1'b0);
    chk("low ready set", rd[3], 1'b1);
    apb(1, `SCPM_ADDR_SYS_MODE, 32'he2);
    repeat (200) @(posedge ref_clk);
    chk("normal mode", mode, scpm_pkg::MODE_NORMAL);
    apb(0, `SCPM_ADDR_SYS_MODE, 0);
    chk("high ready set", rd[2], 1'b1);
    edges = 0;
    prev = system_clock;
    for (int i = 0; i < 320; i++) begin
      @(posedge ref_clk);
      if (system_clock === 1'b1 && prev === 1'b0) edges++;
      prev = system_clock;
    end
    chk("half rate edges", (edges >= 19 && edges <= 21), 1'b1);
  endtask : t_divider
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1;
    @(posedge ref_clk);
    t_reset_values();
    t_sub_select();
    t_bad_code();
    t_halt(1, 1, 0, 0, scpm_pkg::MODE_IDLE_ON);
    t_halt(1, 0, 0, 0, scpm_pkg::MODE_IDLE_OFF);
    t_halt(0, 0, 0, 0, scpm_pkg::MODE_DEEP_SLEEP);
    t_halt(0, 0, 1, 0, scpm_pkg::MODE_LIGHT_SLEEP);
    t_halt(0, 0, 0, 1, scpm_pkg::MODE_LIGHT_SLEEP);
    voltage_detect_enable <= 0;
    wdt_enable <= 0;
    t_divider();
    print_verdict();
  end
endmodule : system_clock_and_power_modes_tb_top
